// ==== verilog/cgc_regs.sv ====
/*
 Control bytes 6 to 10 of a clock generator: drive modes, test mode,
 software peripheral stop, drive strengths, video spread, strap readback.
 Assumes a management bus front end on mclk issuing one-cycle wr/rd
 strobes; stop, power-down and strap pins are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module cgc_regs (
    input wire logic mclk,
    input wire logic resetn,
    input wire cgc_pkg::cgc_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic peripheral_stop_request_n,
    input wire logic processor_stop_request_n,
    input wire logic power_down_input,
    input wire logic freq_strap_a,
    input wire logic freq_strap_b,
    input wire logic freq_strap_c,
    input wire logic supply_good_strobe_n,
    input wire logic [9:0] src_stop_ctrl,
    input wire logic [2:0] cpu_stop_ctrl,
    input wire logic free_peripheral_out0_stop_ctrl,
    input wire logic out_clk_tick,
    output var cgc_pkg::cgc_cfg_t cfg,
    output logic peripheral_stopped,
    output logic [9:0] src_run,
    output logic [9:0] src_drive_en,
    output logic [2:0] cpu_drive_en,
    output logic free_peripheral_out0_run
);
    import cgc_pkg::*;

    logic [7:0] drive_mode;
    logic [7:0] test_ctrl;
    logic [7:0] strength;
    logic [7:0] spread;
    logic [2:0] straps;
    logic strap_taken;
    logic [6:0] pins_s;
    logic hw_pstop;
    logic hw_cstop;
    logic pd;
    logic pgood;
    logic stop_cond;
    logic [7:0] next_rdata;

    // Masked byte update, shared by the test, strength and spread bytes
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] val,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction : merge

    cgc_sync #(.W(7)) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .d({~peripheral_stop_request_n, ~processor_stop_request_n,
            power_down_input, ~supply_good_strobe_n,
            freq_strap_c, freq_strap_b, freq_strap_a}),
        .q(pins_s)
    );

    assign hw_pstop = pins_s[6];
    assign hw_cstop = pins_s[5];
    assign pd = pins_s[4];
    assign pgood = pins_s[3];

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            drive_mode <= RST_DRIVE;
        else if (req.wr && req.addr == OFF_DRIVE)
            drive_mode <= req.wdata; // R1 R2 R3 R4
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            test_ctrl <= RST_TEST; // R5 R7 R9
        else if (req.wr && req.addr == OFF_TEST)
            test_ctrl <= merge(test_ctrl, req.wdata, WMASK_TEST); // R8 R9
    end

    // Straps caught once, on the first strobe after reset
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            straps <= '0;
            strap_taken <= 1'b0;
        end
        else if (pgood && !strap_taken)
        begin
            straps <= pins_s[2:0]; // R10
            strap_taken <= 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            strength <= RST_STRENGTH;
        else if (req.wr && req.addr == OFF_STRENGTH)
            strength <= merge(strength, req.wdata, WMASK_STRENGTH); // R12 R13
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            spread <= RST_SPREAD;
        else if (req.wr && req.addr == OFF_SPREAD)
            spread <= merge(spread, req.wdata, WMASK_SPREAD); // R14 R15 R16
    end

    assign stop_cond = hw_pstop || !test_ctrl[B_SOFT_RUN]; // R18

    // Stop only changes on an output clock low phase tick: no runt pulses
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            peripheral_stopped <= 1'b0;
        else if (out_clk_tick)
            peripheral_stopped <= stop_cond; // R8 R9
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            src_run <= '1;
            free_peripheral_out0_run <= 1'b1;
        end
        else
        begin
            src_run <= ~(src_stop_ctrl & {10{peripheral_stopped}}); // R17
            free_peripheral_out0_run <= !(free_peripheral_out0_stop_ctrl && peripheral_stopped);
        end
    end

    // Drive enables: low only when stopped or powered down with tri-state set, or in test mode with hi-Z selected
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            src_drive_en <= '1;
            cpu_drive_en <= '1;
        end
        else if (cfg.test_mode && !cfg.test_ref_div)
        begin
            src_drive_en <= '0; // R6
            cpu_drive_en <= '0;
        end
        else
        begin
            for (int i = 0; i < 10; i++)
                src_drive_en[i] <= !((peripheral_stopped && src_stop_ctrl[i]
                                      && drive_mode[B_SRC_STOP_Z]) // R1 R17
                                     || (pd && i != 0
                                         && drive_mode[B_SRC_PD_Z])); // R3
            for (int j = 0; j < 3; j++)
                cpu_drive_en[j] <= !((hw_cstop && cpu_stop_ctrl[j]
                                      && drive_mode[B_CPU_STOP_Z_LO + j]) // R2
                                     || (pd
                                         && drive_mode[B_CPU_PD_Z_LO
                                                       + j])); // R4
        end
    end

    always_comb
    begin
        cfg.src_stop_z = drive_mode[B_SRC_STOP_Z];
        cfg.cpu_stop_z = drive_mode[B_CPU_STOP_Z_LO +: 3];
        cfg.src_pd_z = drive_mode[B_SRC_PD_Z];
        cfg.cpu_pd_z = drive_mode[B_CPU_PD_Z_LO +: 3];
        cfg.test_mode = test_ctrl[B_TEST_MODE]; // R5
        cfg.test_ref_div = test_ctrl[B_TEST_SEL]; // R6
        cfg.reference_out0_strong = test_ctrl[B_REFERENCE_OUT0_STRONG]; // R7
        cfg.usb_strong = strength[B_USB_STRONG]; // R12
        cfg.free_peripheral_out0_strong = strength[B_FREE_PERIPHERAL_OUT0_STRONG]; // R13
        cfg.spread_depth = cgc_depth_t'(spread[B_SPREAD_LO +: 2]); // R14
        cfg.video_spread_en = spread[B_VIDSS_EN]; // R15
        cfg.spread_on = spread[B_SS_EN]; // R16
    end

    always_comb
    begin
        case (req.addr)
            OFF_DRIVE: next_rdata = drive_mode;
            OFF_TEST: next_rdata = {test_ctrl[7:3], straps}; // R10
            OFF_IDENT: next_rdata = {REVISION_CODE, VENDOR_CODE}; // R11
            OFF_STRENGTH: next_rdata = strength;
            OFF_SPREAD: next_rdata = spread;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= req.rd;
            if (req.rd)
                rdata <= next_rdata;
        end
    end
endmodule : cgc_regs
`default_nettype wire

// ==== verilog/cgc_pkg.sv ====
/*
 Package for the clock generator control bytes 6 to 10: offsets,
 reset values, field positions and the carrier structs.
 Assumes a byte-wide register port fed by a management bus front end.
*/
// Behaviour
// R1: Byte 6 bit 7: serial-ref pairs driven or hi-Z during peripheral stop.
// R2: Byte 6 bits 6..4: processor pairs 2..0 driven or hi-Z in processor stop.
// R3: Byte 6 bit 3: serial-ref pairs 9..1 driven or hi-Z in power-down.
// R4: Byte 6 bits 2..0: processor pairs 2..0 driven or hi-Z in power-down.
// R5: Byte 7 bit 6 enters test clock mode; resets to 0.
// R6: Byte 7 bit 7 in test mode: 0 hi-Z outputs, 1 reference divided by N.
// R7: Byte 7 bit 4 is reference output 0 drive strength; resets high.
// R8: Writing 0 to byte 7 bit 3 stops stoppable outputs without short pulses.
// R9: Writing 1 restarts stopped outputs cleanly; bit resets to 1.
// R10: Byte 7 bits 2..0 are read-only straps latched at supply-good strobe.
// R11: Byte 8 is read-only: revision code high nibble, vendor code low.
// R12: Byte 9 bit 2 is the usb clock drive strength; resets high.
// R13: Byte 9 bit 0 is free peripheral clock 0 drive strength; resets high.
// R14: Byte 10 bits 5..4 select spread depth -0.5,-1.0,-1.5,-2.0 percent.
// R15: Byte 10 bit 2 enables the spread video output; resets to 1.
// R16: Byte 10 bit 1 turns spread modulation on for video and panel clocks.
// R17: Serial-ref pair obeys peripheral stop only if its stop bit is 1.
// R18: Peripheral stop is hardware stop pin OR software stop bit at 0.
package cgc_pkg;
    localparam logic [7:0] OFF_DRIVE = 8'h06;
    localparam logic [7:0] OFF_TEST = 8'h07;
    localparam logic [7:0] OFF_IDENT = 8'h08;
    localparam logic [7:0] OFF_STRENGTH = 8'h09;
    localparam logic [7:0] OFF_SPREAD = 8'h0a;

    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [7:0] RST_TEST = 8'h38;
    localparam logic [7:0] RST_STRENGTH = 8'h07;
    localparam logic [7:0] RST_SPREAD = 8'h0e;

    // Writable masks; straps and reserved bits are kept out
    localparam logic [7:0] WMASK_TEST = 8'hd8;
    localparam logic [7:0] WMASK_STRENGTH = 8'h05;
    localparam logic [7:0] WMASK_SPREAD = 8'h36;

    // Field positions
    localparam int B_SRC_STOP_Z = 7;
    localparam int B_CPU_STOP_Z_LO = 4;
    localparam int B_SRC_PD_Z = 3;
    localparam int B_CPU_PD_Z_LO = 0;
    localparam int B_TEST_SEL = 7;
    localparam int B_TEST_MODE = 6;
    localparam int B_REFERENCE_OUT0_STRONG = 4;
    localparam int B_SOFT_RUN = 3;
    localparam int B_STRAP_LO = 0;
    localparam int B_USB_STRONG = 2;
    localparam int B_FREE_PERIPHERAL_OUT0_STRONG = 0;
    localparam int B_SPREAD_LO = 4;
    localparam int B_VIDSS_EN = 2;
    localparam int B_SS_EN = 1;

    // Identification, values arbitrary
    localparam logic [3:0] REVISION_CODE = 4'h1;
    localparam logic [3:0] VENDOR_CODE = 4'h2;

    // Spread depth encodings
    typedef enum logic [1:0] {
        CGC_SS_0P5 = 2'b00,
        CGC_SS_1P0 = 2'b01,
        CGC_SS_1P5 = 2'b10,
        CGC_SS_2P0 = 2'b11
    } cgc_depth_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cgc_req_t;

    typedef struct packed {
        logic src_stop_z;
        logic [2:0] cpu_stop_z;
        logic src_pd_z;
        logic [2:0] cpu_pd_z;
        logic test_mode;
        logic test_ref_div;
        logic reference_out0_strong;
        logic usb_strong;
        logic free_peripheral_out0_strong;
        cgc_depth_t spread_depth;
        logic video_spread_en;
        logic spread_on;
    } cgc_cfg_t;
endpackage : cgc_pkg

// ==== verilog/cgc_sync.sv ====
/*
 Two flip-flop synchroniser for a bus of pin levels.
 Assumes mclk is running and pins are asynchronous to it.
*/
`timescale 1ns/1ns
`default_nettype none
module cgc_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : cgc_sync
`default_nettype wire

// ==== testbench/cgc_regs_properties.sv ====
/*
 Port checker for cgc_regs, bound into every instance.
 Assumes one clock, mclk, and the synchronous active-low resetn.
*/
`timescale 1ns/1ns
`default_nettype none
module cgc_regs_properties (
    input wire logic mclk,
    input wire logic resetn,
    input wire cgc_pkg::cgc_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire cgc_pkg::cgc_cfg_t cfg,
    input wire logic peripheral_stopped,
    input wire logic out_clk_tick,
    input wire logic [9:0] src_stop_ctrl,
    input wire logic [9:0] src_run,
    input wire logic [9:0] src_drive_en,
    input wire logic [2:0] cpu_drive_en
);
    import cgc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    ident_read_a: assert property (
        req.rd && req.addr == OFF_IDENT |=> rvalid
        && rdata == {REVISION_CODE, VENDOR_CODE})
        else $error("identification byte read wrong");
    drive_write_a: assert property (
        req.wr && req.addr == OFF_DRIVE |=> {cfg.src_stop_z, cfg.cpu_stop_z,
        cfg.src_pd_z, cfg.cpu_pd_z} == $past(req.wdata))
        else $error("drive mode byte not written");
    test_write_a: assert property (
        req.wr && req.addr == OFF_TEST |=> {cfg.test_ref_div, cfg.test_mode,
        cfg.reference_out0_strong} == {$past(req.wdata[7:6]), $past(req.wdata[4])})
        else $error("test byte fields not written");
    strength_write_a: assert property (
        req.wr && req.addr == OFF_STRENGTH |=> {cfg.usb_strong,
        cfg.free_peripheral_out0_strong} == {$past(req.wdata[2]), $past(req.wdata[0])})
        else $error("strength byte not written");
    spread_write_a: assert property (
        req.wr && req.addr == OFF_SPREAD |=> {cfg.spread_depth,
        cfg.video_spread_en, cfg.spread_on} ==
        {$past(req.wdata[5:4]), $past(req.wdata[2:1])})
        else $error("spread byte not written");
    stop_at_tick_a: assert property (
        $changed(peripheral_stopped) |-> $past(out_clk_tick))
        else $error("stop changed away from safe point");
    stopped_pairs_a: assert property (
        (peripheral_stopped && $stable(src_stop_ctrl)) [*8] |->
        src_run == ~src_stop_ctrl)
        else $error("serial ref pair run state wrong in stop");
    test_tristate_a: assert property (
        (cfg.test_mode && !cfg.test_ref_div) [*3] |->
        src_drive_en == 10'h000 && cpu_drive_en == 3'b000)
        else $error("outputs driven in test tri-state");
endmodule : cgc_regs_properties
bind cgc_regs cgc_regs_properties u_cgc_regs_properties (.mclk(mclk),
    .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid), .cfg(cfg),
    .peripheral_stopped(peripheral_stopped), .out_clk_tick(out_clk_tick),
    .src_stop_ctrl(src_stop_ctrl), .src_run(src_run),
    .src_drive_en(src_drive_en), .cpu_drive_en(cpu_drive_en));
`default_nettype wire

// ==== testbench/cgc_host.sv ====
/*
 Management bus host model: single byte reads and writes on the register
 port, plus the output clock safe-point tick. Assumes mclk only.
*/
`timescale 1ns/1ns
`default_nettype none
module cgc_host (
    input wire logic mclk,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    output var cgc_pkg::cgc_req_t req,
    output logic out_clk_tick
);
    import cgc_pkg::*;
    logic [1:0] phase = 2'b00;
    initial req = '0;
    // Low phase of a slow output clock, every fourth cycle
    always @(posedge mclk) phase <= phase + 2'b01;
    assign out_clk_tick = (phase == 2'b11);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        req <= '0;
        n = 0;
        @(posedge mclk);
        // Bounded so a missing answer cannot hang the host
        while (rvalid !== 1'b1 && n < 4)
        begin
            n++;
            @(posedge mclk);
        end
        d = rdata;
    endtask : rd
endmodule : cgc_host
`default_nettype wire

// ==== testbench/test_clock_gen_control_regs.sv ====
/*
 Register sequence test of cgc_regs through the host model.
 Assumes the package constants and the bound port checker.
*/
`timescale 1ns/1ns
`default_nettype none
module test_clock_gen_control_regs;
    import cgc_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    cgc_req_t req;
    logic [7:0] rdata;
    logic rvalid, tick, stopped, free_peripheral_out0_run;
    logic pstop_n = 1'b1, cstop_n = 1'b1, pd = 1'b0, good_n = 1'b1;
    logic fs_a = 1'b1;
    logic [9:0] src_run, src_en;
    logic [2:0] cpu_en;
    int n_errors = 0, n_checks = 0, cycles = 0;
    logic [7:0] offs [6] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
    logic [7:0] exps [6] = '{RST_DRIVE, RST_TEST, {REVISION_CODE,
        VENDOR_CODE}, RST_STRENGTH, RST_SPREAD, 8'h00};
    always #20 mclk = ~mclk;
    cgc_host u_cgc_host (.mclk(mclk), .rdata(rdata), .rvalid(rvalid),
        .req(req), .out_clk_tick(tick));
    cgc_regs u_cgc_regs (.mclk(mclk), .resetn(resetn), .req(req),
        .rdata(rdata), .rvalid(rvalid), .peripheral_stop_request_n(pstop_n),
        .processor_stop_request_n(cstop_n), .power_down_input(pd),
        .freq_strap_a(fs_a), .freq_strap_b(1'b0), .freq_strap_c(1'b1),
        .supply_good_strobe_n(good_n), .src_stop_ctrl(10'h00f),
        .cpu_stop_ctrl(3'b111), .free_peripheral_out0_stop_ctrl(1'b1), .out_clk_tick(tick),
        .cfg(), .peripheral_stopped(stopped), .src_run(src_run),
        .src_drive_en(src_en), .cpu_drive_en(cpu_en), .free_peripheral_out0_run(free_peripheral_out0_run));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [9:0] e,
        input logic [9:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_cgc_host.rd(a, d);
        chk("rdata", 10'(e), 10'(d));
    endtask : rchk
    task automatic pins(input logic [9:0] e_run, input logic [9:0] e_en,
        input logic [2:0] e_cpu, input logic e_stop);
        // Two sync flops plus a wait for the safe point
        repeat (12) @(posedge mclk);
        chk("src_run", e_run, src_run);
        chk("src_drive_en", e_en, src_en);
        chk("cpu_drive_en", 10'(e_cpu), 10'(cpu_en));
        chk("stopped", 10'(e_stop), 10'(stopped));
    endtask : pins
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rchk(offs[i], exps[i]);
        good_n <= 1'b0;
        repeat (6) @(posedge mclk);
        fs_a <= 1'b0;
        u_cgc_host.wr(OFF_TEST, 8'hff);
        rchk(OFF_TEST, 8'hfd);
        pins(10'h3ff, 10'h3ff, 3'b111, 1'b0);
        u_cgc_host.wr(OFF_IDENT, 8'h00);
        rchk(OFF_IDENT, {REVISION_CODE, VENDOR_CODE});
        u_cgc_host.wr(OFF_STRENGTH, 8'h00);
        rchk(OFF_STRENGTH, 8'h02);
        for (int d = 0; d < 4; d++)
        begin
            u_cgc_host.wr(OFF_SPREAD, 8'(d << 4));
            rchk(OFF_SPREAD, 8'(d << 4) | 8'h08);
        end
        u_cgc_host.wr(OFF_TEST, 8'h48);
        pins(10'h3ff, 10'h000, 3'b000, 1'b0);
        u_cgc_host.wr(OFF_TEST, 8'h18);
        u_cgc_host.wr(OFF_DRIVE, 8'h88);
        pd <= 1'b1;
        pins(10'h3ff, 10'h001, 3'b111, 1'b0);
        u_cgc_host.wr(OFF_DRIVE, 8'h77);
        pins(10'h3ff, 10'h3ff, 3'b000, 1'b0);
        pd <= 1'b0;
        cstop_n <= 1'b0;
        pins(10'h3ff, 10'h3ff, 3'b000, 1'b0);
        cstop_n <= 1'b1;
        u_cgc_host.wr(OFF_DRIVE, 8'h80);
        u_cgc_host.wr(OFF_TEST, 8'h10);
        pins(10'h3f0, 10'h3f0, 3'b111, 1'b1);
        chk("free_peripheral_out0_run", 10'h000, 10'(free_peripheral_out0_run));
        u_cgc_host.wr(OFF_TEST, 8'h18);
        pins(10'h3ff, 10'h3ff, 3'b111, 1'b0);
        chk("free_peripheral_out0_run", 10'h001, 10'(free_peripheral_out0_run));
        pstop_n <= 1'b0;
        pins(10'h3f0, 10'h3f0, 3'b111, 1'b1);
        pstop_n <= 1'b1;
        pins(10'h3ff, 10'h3ff, 3'b111, 1'b0);
        report_and_stop();
    end
endmodule : test_clock_gen_control_regs
`default_nettype wire
